//--- verilog/fpp_pkg.sv
// Constants, types and register map of the sectored flash program/protect controller.
// Assumes one 8-bit register port on the system clock and a flash array that answers done.
//
// What this block does
// - Stand-alone tool mode lets every sector and the option byte be programmed or erased.
// - In-circuit mode lets every sector and the option byte be programmed or erased.
// - In-application mode protects sector 0 from program and erase; others stay open.
// - 4K gives sector 0, 8K gives sectors 0-1, larger gives sectors 0-2.
// - Sectors 0 and 1 are 4 Kbytes at the top; sector 0 is F000h-FFFFh.
// - Any single sector can be erased alone, leaving the others untouched.
// - Read-out protection bit blocks external read-out and any rewrite of memory.
// - Clearing read-out protection first erases the whole memory automatically.
// - The tool link uses serial clock, serial data, reset and voltage select pins.
// - With a tool attached, serial clock and data pins are taken from the application.
// - One 8-bit control/status register at 002Bh, reset 00h, drives program/erase.
// - A key sequence must arm the registers before any program or erase starts.
// - Erase works per sector or whole block; programming goes one byte at a time.
package fpp_pkg;

   // Register offsets.
   localparam logic [7:0] CTRL_OFS   = 8'h2B;
   localparam logic [7:0] GUARD_OFS  = 8'h70;
   localparam logic [7:0] ADRLO_OFS  = 8'h71;
   localparam logic [7:0] ADRHI_OFS  = 8'h72;
   localparam logic [7:0] DATA_OFS   = 8'h73;
   localparam logic [7:0] OPTION_OFS = 8'h74;
   localparam logic [7:0] LINK_OFS   = 8'h75;
   localparam logic [7:0] STATUS_OFS = 8'h76;

   // Reset values.
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] BYTE_RST   = 8'h00;

   // Control register fields.
   localparam int CTRL_PROG_BIT   = 0;
   localparam int CTRL_SERASE_BIT = 1;
   localparam int CTRL_MERASE_BIT = 2;
   localparam int CTRL_SEC_LSB    = 3;
   localparam int CTRL_REFUSE_BIT = 5;
   localparam int CTRL_BUSY_BIT   = 6;

   // Option register field.
   localparam int OPT_PROTECT_BIT = 0;

   // Guard key sequence; values are arbitrary.
   localparam logic [7:0] GUARD_KEY1 = 8'h56;
   localparam logic [7:0] GUARD_KEY2 = 8'hAE;

   // Memory geometry.
   localparam int          FLASH_SIZE_KB = 32;
   localparam logic [15:0] SEC0_BASE     = 16'hF000;
   localparam logic [15:0] SEC1_BASE     = 16'hE000;
   localparam logic [16:0] FLASH_BASE    = 17'h1_0000 - 17'(FLASH_SIZE_KB * 1024);
   localparam logic [1:0]  NUM_SECTORS   = (FLASH_SIZE_KB <= 4) ? 2'd1 :
                                           (FLASH_SIZE_KB <= 8) ? 2'd2 : 2'd3;

   // Link framing.
   localparam logic [2:0] LINK_LAST_BIT = 3'd7;

   typedef enum logic [1:0] {
      MODE_APP  = 2'd0,
      MODE_ICP  = 2'd1,
      MODE_TOOL = 2'd2
   } fpp_mode_e;

   typedef enum logic [1:0] {
      OP_PROG   = 2'd0,
      OP_SERASE = 2'd1,
      OP_MERASE = 2'd2
   } fpp_op_e;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ISSUE = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_MASS  = 4'b1000
   } fpp_state_e;

   typedef struct packed {
      logic        valid;
      fpp_op_e     op;
      logic [1:0]  sector;
      logic [15:0] addr;
      logic [7:0]  data;
   } fpp_flash_req_s;

endpackage

//--- verilog/fpp_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
// Assumes the input is a level that stays put for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module fpp_sync #(
   parameter int W = 1
) (
   // Destination clock.
   input  wire logic         clock,
   // Level in and synchronised level out.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second.
   always_ff @(posedge clock) begin
      meta_r <= d;
      q      <= meta_r;
   end
endmodule
`default_nettype wire

//--- verilog/fpp_ctrl.sv
// Sectored flash program/erase sequencer with mode protection and read-out lock.
// Assumes a flash array that takes one request pulse and answers with a done pulse,
// and a programming tool that clocks bytes in on its own serial clock.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl
   import fpp_pkg::*;
(
   // System clock and reset.
   input  wire logic     clock,
   input  wire logic     srst,
   // Register port.
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   // Mode straps and stored option bit.
   input  wire logic     toolSocketPin,
   input  wire logic     progVoltageSelect,
   input  wire logic     optionProtectNv,
   // Tool serial link.
   input  wire logic     toolSerialClock,
   input  wire logic     toolSerialDataIn,
   output logic          toolSerialDataOut,
   output logic          toolSerialDataOe,
   // Flash array.
   output fpp_flash_req_s flashReq,
   input  wire logic      flashDone,
   // Pin ownership and read-out gate.
   output logic          appPinsReleased,
   output logic          extReadEnable
);

   // Synchronised pins.
   logic [1:0] pinSync;
   logic       socketSync;
   logic       selectSync;

   fpp_sync #(.W(2)) u_pin_sync (
      .clock (clock),
      .d     ({toolSocketPin, progVoltageSelect}),
      .q     (pinSync)
   );

   assign socketSync = pinSync[1];
   assign selectSync = pinSync[0];

   // Mode latched once after reset release.
   fpp_mode_e  mode_r;
   logic       strapDone_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         mode_r      <= MODE_APP;
         strapDone_r <= 1'b0;
      end else if (!strapDone_r) begin
         strapDone_r <= 1'b1;
         if (socketSync)
            mode_r <= MODE_TOOL;
         else if (selectSync)
            mode_r <= MODE_ICP;
         else
            mode_r <= MODE_APP;
      end
   end

   // Tool attached frees the serial pins from the application.
   always_ff @(posedge clock) begin
      if (srst)
         appPinsReleased <= 1'b0;
      else
         appPinsReleased <= selectSync || (mode_r == MODE_ICP);
   end

   // Link domain: serial receiver on the tool clock.
   logic       linkRst;
   logic [2:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] linkByte_r;
   logic       linkTog_r;
   fpp_sync #(.W(1)) u_link_rst (
      .clock (toolSerialClock),
      .d     (srst),
      .q     (linkRst)
   );
   always_ff @(posedge toolSerialClock) begin
      if (linkRst) begin
         bitCnt_r   <= 3'd0;
         shift_r    <= BYTE_RST;
         linkByte_r <= BYTE_RST;
         linkTog_r  <= 1'b0;
      end else begin
         shift_r  <= {shift_r[6:0], toolSerialDataIn};
         bitCnt_r <= bitCnt_r + 3'd1;
         if (bitCnt_r == LINK_LAST_BIT) begin
            linkByte_r <= {shift_r[6:0], toolSerialDataIn};
            linkTog_r  <= ~linkTog_r;
         end
      end
   end

   // The device only listens on the data pin.
   assign toolSerialDataOut = 1'b0;
   assign toolSerialDataOe  = 1'b0;

   // Byte crossing: toggle synchronised, data held stable meanwhile.
   logic       togSync;
   logic       togSeen_r;
   logic [7:0] linkRx_r;
   fpp_sync #(.W(1)) u_tog_sync (
      .clock (clock),
      .d     (linkTog_r),
      .q     (togSync)
   );
   always_ff @(posedge clock) begin
      if (srst) begin
         togSeen_r <= 1'b0;
         linkRx_r  <= BYTE_RST;
      end else begin
         togSeen_r <= togSync;
         if (togSync != togSeen_r)
            linkRx_r <= linkByte_r;
      end
   end

   // Register writes.
   logic       wrCtrl;
   logic       wrGuard;
   logic       wrOption;
   assign wrCtrl   = regWr && (regAddr == CTRL_OFS);
   assign wrGuard  = regWr && (regAddr == GUARD_OFS);
   assign wrOption = regWr && (regAddr == OPTION_OFS);
   logic [15:0] addr_r;
   logic [7:0]  data_r;
   logic [1:0]  sector_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         addr_r <= 16'h0000;
         data_r <= BYTE_RST;
      end else begin
         if (regWr && regAddr == ADRLO_OFS)
            addr_r[7:0] <= regWrData;
         if (regWr && regAddr == ADRHI_OFS)
            addr_r[15:8] <= regWrData;
         if (regWr && regAddr == DATA_OFS)
            data_r <= regWrData;
      end
   end

   // Guard: two keys in order arm one control or option write.
   logic keyOne_r;
   logic armed_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         keyOne_r <= 1'b0;
         armed_r  <= 1'b0;
      end else if (wrGuard) begin
         keyOne_r <= (regWrData == GUARD_KEY1);
         armed_r  <= keyOne_r && (regWrData == GUARD_KEY2);
      end else if (wrCtrl || wrOption) begin
         keyOne_r <= 1'b0;
         armed_r  <= 1'b0;
      end
   end

   // Sector of the program address.
   logic [1:0] addrSector;
   logic       addrInFlash;
   always_comb begin
      addrInFlash = ({1'b0, addr_r} >= FLASH_BASE);
      if (addr_r >= SEC0_BASE)
         addrSector = 2'd0;
      else if (addr_r >= SEC1_BASE)
         addrSector = 2'd1;
      else
         addrSector = 2'd2;
   end

   // Protection per mode.
   logic protect_r;
   function automatic logic sectorOpen(input logic [1:0] sec,
                                       input fpp_mode_e  md);
      sectorOpen = (sec < NUM_SECTORS) &&
                   !((md == MODE_APP) && (sec == 2'd0));
   endfunction

   // Request decode.
   logic       reqProg;
   logic       reqSErase;
   logic       reqMErase;
   logic       reqAny;
   logic       reqOk;
   logic [1:0] ctrlSector;
   fpp_op_e    reqOp;
   assign ctrlSector = regWrData[CTRL_SEC_LSB +: 2];
   assign reqProg    = wrCtrl && regWrData[CTRL_PROG_BIT];
   assign reqSErase  = wrCtrl && regWrData[CTRL_SERASE_BIT];
   assign reqMErase  = wrCtrl && regWrData[CTRL_MERASE_BIT];
   assign reqAny     = reqProg || reqSErase || reqMErase;
   fpp_state_e state_r;
   always_comb begin
      reqOp = OP_PROG;
      reqOk = 1'b0;
      if (armed_r && !protect_r && state_r == ST_IDLE) begin
         if (reqMErase) begin
            reqOp = OP_MERASE;
            reqOk = (mode_r != MODE_APP);
         end else if (reqSErase) begin
            reqOp = OP_SERASE;
            reqOk = sectorOpen(ctrlSector, mode_r);
         end else if (reqProg) begin
            reqOp = OP_PROG;
            reqOk = addrInFlash && sectorOpen(addrSector, mode_r);
         end
      end
   end

   // Option write: clearing protection needs a full erase first.
   logic optClearReq;
   logic optSetReq;
   logic optOk;

   assign optOk       = wrOption && armed_r && (mode_r != MODE_APP) &&
                        (state_r == ST_IDLE);
   assign optClearReq = optOk && protect_r && !regWrData[OPT_PROTECT_BIT];
   assign optSetReq   = optOk && regWrData[OPT_PROTECT_BIT];

   // Sequencer.
   fpp_state_e state_nxt;
   logic       massDone;
   assign massDone = (state_r == ST_MASS) && flashDone;
   always_comb begin
      case (state_r)
         ST_IDLE: begin
            if (optClearReq)
               state_nxt = ST_MASS;
            else if (reqOk && reqAny)
               state_nxt = ST_ISSUE;
            else
               state_nxt = ST_IDLE;
         end
         ST_ISSUE: state_nxt = ST_WAIT;
         ST_WAIT:  state_nxt = flashDone ? ST_IDLE : ST_WAIT;
         ST_MASS:  state_nxt = flashDone ? ST_IDLE : ST_MASS;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // Held operation fields.
   fpp_op_e opHold_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         opHold_r <= OP_PROG;
         sector_r <= 2'd0;
      end else if (state_r == ST_IDLE && reqOk) begin
         opHold_r <= reqOp;
         sector_r <= ctrlSector;
      end
   end

   // Flash request, one pulse per operation.
   always_ff @(posedge clock) begin
      if (srst) begin
         flashReq <= '0;
      end else begin
         flashReq.valid  <= 1'b0;
         flashReq.addr   <= addr_r;
         flashReq.data   <= data_r;
         flashReq.sector <= sector_r;
         if (state_r == ST_ISSUE) begin
            flashReq.valid <= 1'b1;
            flashReq.op    <= opHold_r;
         end else if (state_r == ST_IDLE && optClearReq) begin
            flashReq.valid <= 1'b1;
            flashReq.op    <= OP_MERASE;
         end
      end
   end

   // Read-out protection bit; cleared only after the mass erase ends.
   always_ff @(posedge clock) begin
      if (srst)
         protect_r <= 1'b0;
      else if (!strapDone_r)
         protect_r <= optionProtectNv;
      else if (massDone)
         protect_r <= 1'b0;
      else if (optSetReq)
         protect_r <= 1'b1;
   end

   always_ff @(posedge clock) begin
      if (srst)
         extReadEnable <= 1'b0;
      else
         extReadEnable <= strapDone_r && !protect_r &&
                          (state_r != ST_MASS);
   end

   // Refused flag: set wins over the write-one clear.
   logic refused_r;
   logic refuseEvt;

   assign refuseEvt = (reqAny && !reqOk) ||
                      (wrOption && !optOk);

   always_ff @(posedge clock) begin
      if (srst)
         refused_r <= 1'b0;
      else if (refuseEvt)
         refused_r <= 1'b1;
      else if (wrCtrl && regWrData[CTRL_REFUSE_BIT])
         refused_r <= 1'b0;
   end

   // Control register image; start bits read back while busy.
   logic [7:0] ctrlImg;
   logic       busy;

   assign busy = (state_r != ST_IDLE);

   always_comb begin
      ctrlImg                             = CTRL_RST;
      ctrlImg[CTRL_PROG_BIT]              = busy && (opHold_r == OP_PROG);
      ctrlImg[CTRL_SERASE_BIT]            = busy && (opHold_r == OP_SERASE);
      ctrlImg[CTRL_MERASE_BIT]            = (state_r == ST_MASS) ||
                                            (busy && opHold_r == OP_MERASE);
      ctrlImg[CTRL_SEC_LSB +: 2]          = sector_r;
      ctrlImg[CTRL_REFUSE_BIT]            = refused_r;
      ctrlImg[CTRL_BUSY_BIT]              = busy;
   end

   // Read data, one cycle after the strobe.
   logic [7:0] rdMux;

   always_comb begin
      case (regAddr)
         CTRL_OFS:   rdMux = ctrlImg;
         ADRLO_OFS:  rdMux = addr_r[7:0];
         ADRHI_OFS:  rdMux = addr_r[15:8];
         DATA_OFS:   rdMux = data_r;
         OPTION_OFS: rdMux = {7'h00, protect_r};
         LINK_OFS:   rdMux = linkRx_r;
         STATUS_OFS: rdMux = {2'b00, NUM_SECTORS, armed_r, protect_r, mode_r};
         default:    rdMux = BYTE_RST;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst)
         regRdData <= BYTE_RST;
      else if (regRd)
         regRdData <= rdMux;
      else
         regRdData <= BYTE_RST;
   end

endmodule
`default_nettype wire

//--- sim/fpp_ctrl_sva.sv
// Concurrent checks on the ports of the flash program/protect controller.
// Assumes it is bound onto fpp_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_chk
   import fpp_pkg::*;
(
   input wire logic           clock,
   input wire logic           srst,
   input wire logic [7:0]     regAddr,
   input wire logic [7:0]     regWrData,
   input wire logic           regWr,
   input wire logic           regRd,
   input wire logic [7:0]     regRdData,
   input wire logic           toolSocketPin,
   input wire logic           progVoltageSelect,
   input wire logic           optionProtectNv,
   input wire logic           toolSerialClock,
   input wire logic           toolSerialDataIn,
   input wire logic           toolSerialDataOut,
   input wire logic           toolSerialDataOe,
   input wire fpp_flash_req_s flashReq,
   input wire logic           flashDone,
   input wire logic           appPinsReleased,
   input wire logic           extReadEnable
);
   logic       opWrite;
   logic       massSeen_r;
   logic [2:0] cyc_r;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   assign opWrite = regWr && (regAddr == CTRL_OFS || regAddr == OPTION_OFS);
   // Notes a whole erase and counts the first cycles after reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         massSeen_r <= 1'b0;
         cyc_r      <= 3'h0;
      end else begin
         if (flashReq.valid && flashReq.op == OP_MERASE) begin
            massSeen_r <= 1'b1;
         end
         if (cyc_r != 3'h7) begin
            cyc_r <= cyc_r + 3'h1;
         end
      end
   end
   property p_rd_idle;
      !$past(regRd) |-> regRdData == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_req_pulse;
      flashReq.valid |=> !flashReq.valid;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
   property p_req_cause;
      flashReq.valid |-> $past(opWrite, 2) || $past(opWrite);
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("request without a write");
   property p_app_sec0;
      flashReq.valid && !toolSocketPin && !progVoltageSelect |->
         (flashReq.op == OP_PROG) ? (flashReq.addr < SEC0_BASE) :
         (flashReq.op == OP_SERASE && flashReq.sector != 2'd0);
   endproperty
   a_app_sec0: assert property (p_app_sec0) else $error("protected sector touched");
   property p_sec_range;
      flashReq.valid && flashReq.op == OP_SERASE |-> flashReq.sector < NUM_SECTORS;
   endproperty
   a_sec_range: assert property (p_sec_range) else $error("sector out of range");
   property p_pins;
      $fell(srst) && progVoltageSelect |-> ##2 appPinsReleased;
   endproperty
   a_pins: assert property (p_pins) else $error("pins kept by application");
   property p_read_lock;
      $fell(srst) && optionProtectNv |-> ##2 !extReadEnable [*3];
   endproperty
   a_read_lock: assert property (p_read_lock) else $error("read-out not blocked");
   property p_unlock_erase;
      $rose(extReadEnable) |-> massSeen_r || cyc_r < 3'h5;
   endproperty
   a_unlock_erase: assert property (p_unlock_erase) else $error("unlock without erase");
endmodule
bind fpp_ctrl fpp_ctrl_chk fpp_ctrl_chk_i (.clock(clock), .srst(srst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .toolSocketPin(toolSocketPin), .progVoltageSelect(progVoltageSelect),
   .optionProtectNv(optionProtectNv), .toolSerialClock(toolSerialClock),
   .toolSerialDataIn(toolSerialDataIn), .toolSerialDataOut(toolSerialDataOut),
   .toolSerialDataOe(toolSerialDataOe), .flashReq(flashReq), .flashDone(flashDone),
   .appPinsReleased(appPinsReleased), .extReadEnable(extReadEnable));
`default_nettype wire

//--- sim/fpp_tool_model.sv
// Programming tool model: voltage select, serial clock and serial data.
// Assumes the bench calls its tasks; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module fpp_tool_model (
   // Tool link pins.
   output logic toolSerialClock,
   output logic toolSerialData,
   output logic attached
);
   initial begin
      toolSerialClock = 1'b0;
      toolSerialData  = 1'b1;
      attached        = 1'b0;
   end
   // Puts the device into serial communication mode.
   task automatic attach(input logic on);
      attached <= on;
   endtask
   // Bare clock pulses, used while reset is held and again just after it is released.
   task automatic run_clock(input int n);
      repeat (n) begin
         #7.5 toolSerialClock = 1'b1;
         #7.5 toolSerialClock = 1'b0;
      end
   endtask
   // One byte MSB first; the released line shows the inverse bit.
   task automatic send_byte(input logic [7:0] b);
      #3.3;
      for (int i = 7; i >= 0; i--) begin
         toolSerialData = b[i];
         #7.5 toolSerialClock = 1'b1;
         #7.5 toolSerialClock = 1'b0;
      end
      toolSerialData = ~b[0];
   endtask
endmodule
`default_nettype wire

//--- sim/test_flash_sector_program_protect.sv
// Self-checking bench for the flash program/protect controller.
// Assumes the tool model drives the link and a small array model here answers.
`timescale 1ns/1ps
`default_nettype none
module test_flash_sector_program_protect;
   import fpp_pkg::*;
   localparam logic [28:0] MP = 29'h1CFF_FFFF;
   localparam logic [28:0] MS = 29'h1F00_0000;
   localparam logic [28:0] MM = 29'h1C00_0000;
   logic           clock, srst, regWr, regRd, toolSocketPin, optionProtectNv, flashDone;
   logic [7:0]     regAddr, regWrData, regRdData, b;
   logic           tsClk, tsDat, vsel, dOut, dOe, pinsRel, extRd, rdSeen;
   fpp_flash_req_s flashReq;
   logic [57:0]    reqQ[$], rdQ[$];
   int             num_errors = 0, n_compared = 0, cycles = 0, doneCnt = 0;
   fpp_ctrl fpp_ctrl_i (.clock(clock), .srst(srst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .toolSocketPin(toolSocketPin), .progVoltageSelect(vsel),
      .optionProtectNv(optionProtectNv), .toolSerialClock(tsClk), .toolSerialDataIn(tsDat),
      .toolSerialDataOut(dOut), .toolSerialDataOe(dOe), .flashReq(flashReq),
      .flashDone(flashDone), .appPinsReleased(pinsRel), .extReadEnable(extRd));
   fpp_tool_model fpp_tool_model_i (.toolSerialClock(tsClk), .toolSerialData(tsDat),
      .attached(vsel));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [28:0] seen, input logic [28:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Watches outputs and takes the oldest expected note for each result.
   always @(posedge clock) begin
      logic [57:0] e;
      if (rdSeen === 1'b1) begin
         e = rdQ.pop_front();
         check(29'(regRdData & e[36:29]), e[28:0]);
      end
      if (flashReq.valid === 1'b1) begin
         e = (reqQ.size() > 0) ? reqQ.pop_front() : '1;
         check(flashReq & e[57:29], e[28:0]);
      end
      rdSeen <= regRd;
   end
   // Flash array answers each request after a random delay.
   always @(posedge clock) begin
      flashDone <= 1'b0;
      if (flashReq.valid === 1'b1) begin
         doneCnt <= 1 + $urandom_range(3);
      end else if (doneCnt == 1) begin
         flashDone <= 1'b1;
         doneCnt   <= 0;
      end else if (doneCnt > 1) begin
         doneCnt <= doneCnt - 1;
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   function automatic logic [28:0] req(input fpp_op_e op, input logic [1:0] s);
      return {1'b1, op, s, 24'h80_0000};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      @(posedge clock);
      regRd   <= 1'b1;
      regAddr <= a;
      rdQ.push_back({21'h0, m, 21'h0, x});
      @(posedge clock);
      regRd <= 1'b0;
   endtask
   task automatic do_reset(input logic sock, input logic att, input logic prot);
      @(posedge clock);
      srst            <= 1'b1;
      toolSocketPin   <= sock;
      optionProtectNv <= prot;
      fpp_tool_model_i.attach(att);
      fpp_tool_model_i.run_clock(4);
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      repeat (3) @(posedge clock);
      // Two link edges let the link-side reset fall before the first frame.
      fpp_tool_model_i.run_clock(2);
   endtask
   task automatic launch(input logic [15:0] a, input logic [7:0] w, input logic [7:0] v,
                         input logic arm, input logic ok, input logic [28:0] m,
                         input logic [28:0] x);
      logic [7:0] d;
      d = 8'($urandom());
      wr(ADRLO_OFS, a[7:0]);
      wr(ADRHI_OFS, a[15:8]);
      wr(DATA_OFS, d);
      if (arm) begin
         wr(GUARD_OFS, GUARD_KEY1);
         wr(GUARD_OFS, GUARD_KEY2);
      end
      if (ok) begin
         reqQ.push_back({m, (x | {5'h00, a, d}) & m});
      end
      wr(w, v);
      for (int i = 0; i < 40 && ok; i++) begin
         @(posedge clock);
         if (flashDone === 1'b1) break;
      end
      repeat (3) @(posedge clock);
      rd(CTRL_OFS, 8'h60, ok ? 8'h00 : 8'h20);
      if (!ok) begin
         wr(CTRL_OFS, 8'h20);
      end
   endtask
   initial begin
      void'($urandom(48));
      {srst, regWr, regRd, toolSocketPin, optionProtectNv} = 5'h10;
      {regAddr, regWrData} = 16'h0000;
      do_reset(1'b0, 1'b0, 1'b0);
      rd(CTRL_OFS, 8'hFF, CTRL_RST);
      rd(8'h10, 8'hFF, 8'h00);
      rd(STATUS_OFS, 8'hFF, 8'h30);
      check(29'(extRd), 29'h1);
      check(29'(pinsRel), 29'h0);
      check(29'({dOut, dOe}), 29'h0);
      launch(16'h8000, CTRL_OFS, 8'h01, 1, 1, MP, req(OP_PROG, 0));
      launch(16'hF000, CTRL_OFS, 8'h01, 1, 0, MP, 0);
      launch(16'h7FFF, CTRL_OFS, 8'h01, 1, 0, MP, 0);
      launch(16'h9000, CTRL_OFS, 8'h01, 0, 0, MP, 0);
      launch(16'h8000, CTRL_OFS, 8'h04, 1, 0, MM, 0);
      for (int s = 0; s < 4; s++) begin
         launch(16'h8000, CTRL_OFS, {3'b000, 2'(s), 3'b010}, 1, s inside {1, 2}, MS,
                req(OP_SERASE, 2'(s)));
      end
      do_reset(1'b0, 1'b1, 1'b0);
      rd(STATUS_OFS, 8'hFF, 8'h31);
      check(29'(pinsRel), 29'h1);
      launch(16'hF000, CTRL_OFS, 8'h01, 1, 1, MP, req(OP_PROG, 0));
      launch(16'h8000, CTRL_OFS, 8'h02, 1, 1, MS, req(OP_SERASE, 0));
      launch(16'h8000, CTRL_OFS, 8'h04, 1, 1, MM, req(OP_MERASE, 0));
      b = 8'($urandom());
      fpp_tool_model_i.send_byte(b);
      repeat (6) @(posedge clock);
      rd(LINK_OFS, 8'hFF, b);
      do_reset(1'b1, 1'b0, 1'b1);
      check(29'(extRd), 29'h0);
      launch(16'h8000, CTRL_OFS, 8'h01, 1, 0, MP, 0);
      launch(16'h8000, OPTION_OFS, 8'h00, 1, 1, MM, req(OP_MERASE, 0));
      check(29'(extRd), 29'h1);
      launch(16'hF000, CTRL_OFS, 8'h01, 1, 1, MP, req(OP_PROG, 0));
      rd(STATUS_OFS, 8'hFF, 8'h32);
      wr(GUARD_OFS, GUARD_KEY1);
      wr(GUARD_OFS, GUARD_KEY2);
      wr(OPTION_OFS, 8'h01);
      repeat (2) @(posedge clock);
      check(29'(extRd), 29'h0);
      repeat (5) @(posedge clock);
      check(29'(reqQ.size()), 29'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
